// ==== core/wdp_pkg.sv ====
// shared constants and types for the watchdog with postscaler
`default_nettype none
package wdp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int BASE_PERIOD_MS = 4;
    // base period in system clock cycles
    localparam int BASE_CYCLES = (CLK_HZ / 1000) * BASE_PERIOD_MS;
    localparam int BASE_W = 18;
    localparam int POST_W = 16;
    localparam int SEL_W = 4;
    localparam int FREQ_W = 3;
    // longest period, in milliseconds (4 ms * 32768)
    localparam int LONGEST_MS = 131072;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'hF;
    localparam logic SWEN_RESET = 1'b0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic sleep_exec;
        logic clear_exec;
        logic clk_fail;
    } wdp_clr_t;

    typedef struct packed {
        logic cfg_enable;
        logic [SEL_W-1:0] post_sel;
    } wdp_cfg_t;
endpackage
`default_nettype wire

// ==== core/wdp_sync.sv ====
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module wdp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    // next values, first stage read only by second
    always_comb begin
        meta_nxt = rstn_i ? d_i : RST_VAL;
        q_nxt = rstn_i ? meta_r : RST_VAL;
    end

    // registers
    always_ff @(posedge clk_i) begin
        meta_r <= meta_nxt;
        q_o <= q_nxt;
    end
endmodule
`default_nettype wire

// ==== core/wdp_top.sv ====
// watchdog timer with 16-bit postscaler
`timescale 1ns/1ps
`default_nettype none
module wdp_top
#(
    parameter int BASE_COUNT = wdp_pkg::BASE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire wdp_pkg::wdp_cfg_t cfg_i,
    input wire wdp_pkg::wdp_clr_t clr_i,
    input wire logic sleeping_i,
    input wire logic clk_fail_i,
    input wire logic [wdp_pkg::FREQ_W-1:0] osc_freq_sel_i,
    input wire logic ctl_wr_i,
    input wire logic ctl_swen_i,
    output logic ctl_swen_o,
    output logic osc_enable_o,
    output logic active_o,
    output logic timeout_reset_o,
    output logic timeout_wake_o,
    output logic [wdp_pkg::POST_W-1:0] post_count_o
);
    import wdp_pkg::*;

    // ------------------------------------------------------------
    // clock failure pin synchronised
    // ------------------------------------------------------------
    logic fail_s;
    wdp_sync #(.RST_VAL(1'b0)) u_fail_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(clk_fail_i),
        .q_o(fail_s)
    );

    // ------------------------------------------------------------
    // control register and clear detection
    // ------------------------------------------------------------
    logic swen_r, swen_nxt;
    logic [FREQ_W-1:0] freq_r, freq_nxt;
    logic enable;
    logic freq_chg;
    logic clear_any;

    // software enable only overrides a disabled config
    assign enable = cfg_i.cfg_enable | swen_r;
    // any change of the select field
    assign freq_chg = (osc_freq_sel_i != freq_r);
    assign clear_any = clr_i.sleep_exec | clr_i.clear_exec
        | clr_i.clk_fail | fail_s | freq_chg;

    // control next values
    always_comb begin
        swen_nxt = swen_r;
        freq_nxt = osc_freq_sel_i;
        if (ctl_wr_i) begin
            swen_nxt = ctl_swen_i;
        end
        if (!rstn_i) begin
            swen_nxt = SWEN_RESET;
            freq_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        swen_r <= swen_nxt;
        freq_r <= freq_nxt;
    end

    // ------------------------------------------------------------
    // base counter and postscaler
    // ------------------------------------------------------------
    logic [BASE_W-1:0] base_r, base_nxt;
    logic [POST_W-1:0] post_r, post_nxt;
    logic tick;
    logic expire;
    logic [POST_W-1:0] mask;
    logic rst_o_nxt, wake_o_nxt;

    assign tick = (base_r == BASE_W'(BASE_COUNT - 1));
    // mask of low bits gives 2^sel periods
    assign mask = POST_W'((32'h1 << cfg_i.post_sel) - 32'h1);
    assign expire = enable && !clear_any && tick
        && ((post_r & mask) == mask);

    // counters next values
    always_comb begin
        base_nxt = base_r;
        post_nxt = post_r;
        rst_o_nxt = 1'b0;
        wake_o_nxt = 1'b0;
        if (!enable || clear_any) begin
            base_nxt = '0;
            post_nxt = '0;
        end else if (tick) begin
            base_nxt = '0;
            post_nxt = expire ? '0 : post_r + POST_W'(1);
        end else begin
            base_nxt = base_r + BASE_W'(1);
        end
        // reset when running, wake when asleep
        rst_o_nxt = expire && !sleeping_i;
        wake_o_nxt = expire && sleeping_i;
        if (!rstn_i) begin
            base_nxt = '0;
            post_nxt = '0;
            rst_o_nxt = 1'b0;
            wake_o_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        base_r <= base_nxt;
        post_r <= post_nxt;
        timeout_reset_o <= rst_o_nxt;
        timeout_wake_o <= wake_o_nxt;
    end

    // ------------------------------------------------------------
    // registered status outputs
    // ------------------------------------------------------------
    logic osc_en_nxt;
    logic active_nxt;
    logic swen_o_nxt;
    logic [POST_W-1:0] post_o_nxt;

    // enabling requests oscillator
    // the request lags enable by one cycle, so the oscillator
    // owner must tolerate one cycle of counting before it runs
    always_comb begin
        osc_en_nxt = enable;
        active_nxt = enable;
        swen_o_nxt = swen_nxt;
        post_o_nxt = post_nxt;
        if (!rstn_i) begin
            osc_en_nxt = 1'b0;
            active_nxt = 1'b0;
            swen_o_nxt = SWEN_RESET;
            post_o_nxt = '0;
        end
    end

    // status registers only, every output from a flop
    always_ff @(posedge clk_i) begin
        osc_enable_o <= osc_en_nxt;
        active_o <= active_nxt;
        ctl_swen_o <= swen_o_nxt;
        post_count_o <= post_o_nxt;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_CLEAR_INSTR: assert property (
        (clr_i.clear_exec | clr_i.sleep_exec) |=> post_count_o == '0)
        else $error("clear instruction did not clear postscaler");
    AST_FREQ_CLEAR: assert property (
        (osc_freq_sel_i != $past(osc_freq_sel_i)) ##0 $past(rstn_i)
        |=> post_count_o == '0)
        else $error("frequency change did not clear postscaler");
    AST_FAIL_CLEAR: assert property (
        clr_i.clk_fail |=> post_count_o == '0)
        else $error("clock failure did not clear postscaler");
    AST_SWEN: assert property (
        (!cfg_i.cfg_enable && !swen_r) |=> !timeout_reset_o)
        else $error("timeout while watchdog disabled");
    AST_OSC_EN: assert property (
        enable |=> osc_enable_o)
        else $error("oscillator not requested while enabled");
    AST_BASE_BOUND: assert property (
        base_r <= BASE_W'(BASE_COUNT - 1))
        else $error("base counter past period");
    AST_WAKE: assert property (
        (expire && sleeping_i) |=> timeout_wake_o && !timeout_reset_o)
        else $error("sleeping expiry did not wake");
    AST_RESET: assert property (
        (expire && !sleeping_i) |=> timeout_reset_o)
        else $error("running expiry did not reset");
    AST_POST_BOUND: assert property (
        (tick && enable && !clear_any) |-> post_r <= mask)
        else $error("postscaler passed selected output");
    AST_FAIL_PIN: assert property (
        fail_s |=> post_count_o == '0)
        else $error("synchronised clock failure did not clear");
    AST_SWEN_READ: assert property (
        ctl_wr_i |=> ctl_swen_o == $past(ctl_swen_i))
        else $error("software enable readback wrong");
    AST_DISABLED_HOLD: assert property (
        !enable |=> post_count_o == '0)
        else $error("postscaler counted while disabled");
    AST_EXPIRE_RESTART: assert property (
        expire |=> post_count_o == '0)
        else $error("postscaler not restarted after expiry");
    // a pulse longer than one cycle would reset the core twice
    AST_PULSE_ONE: assert property (
        (timeout_reset_o | timeout_wake_o)
        |=> !(timeout_reset_o | timeout_wake_o))
        else $error("timeout pulse longer than one cycle");

    COV_RESET: cover property (expire && !sleeping_i);
    COV_WAKE: cover property (expire && sleeping_i);
    COV_SWEN: cover property (!cfg_i.cfg_enable && swen_r && tick);
    COV_FREQ: cover property (freq_chg && post_r != '0);
    COV_FAIL_PIN: cover property (fail_s && post_r != '0);
endmodule
`default_nettype wire

// ==== tb/wdp_top_tb.sv ====
// self-checking bench for the watchdog with postscaler
`timescale 1ns/1ps
`default_nettype none
module wdp_top_tb;
    import wdp_pkg::*;
    // short base period keeps every timeout at most 128 cycles long
    localparam int BC = 4;
    logic clk_i, rstn_i, sleeping_i, clk_fail_i, ctl_wr_i, ctl_swen_i;
    wdp_cfg_t cfg_i;
    wdp_clr_t clr_i;
    logic [FREQ_W-1:0] osc_freq_sel_i;
    logic ctl_swen_o, osc_enable_o, active_o;
    logic timeout_reset_o, timeout_wake_o;
    logic [POST_W-1:0] post_count_o;
    int num_errors = 0;
    int n_tests = 0;

    wdp_top #(.BASE_COUNT(BC)) uut (.clk_i, .rstn_i, .cfg_i, .clr_i,
        .sleeping_i, .clk_fail_i, .osc_freq_sel_i, .ctl_wr_i,
        .ctl_swen_i, .ctl_swen_o, .osc_enable_o, .active_o,
        .timeout_reset_o, .timeout_wake_o, .post_count_o);

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp,
                             input string m);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // one write of the software enable bit
    task automatic write_ctl(input logic v);
        ctl_swen_i = v;
        ctl_wr_i = 1'b1;
        @(negedge clk_i);
        ctl_wr_i = 1'b0;
        @(negedge clk_i);
    endtask

    // one-cycle clear event of kind k; the freq change stays in place
    task automatic kick(input int k);
        case (k)
            0: clr_i.clear_exec = 1'b1;
            1: clr_i.sleep_exec = 1'b1;
            2: clr_i.clk_fail = 1'b1;
            3: clk_fail_i = 1'b1;
            default: osc_freq_sel_i = osc_freq_sel_i + 3'h3;
        endcase
        @(negedge clk_i);
        clr_i = '0;
        clk_fail_i = 1'b0;
    endtask

    // cycles until a timeout pulse; one cycle of slack either way
    task automatic measure(input int exp, input logic wake);
        int n;
        n = 0;
        while ((wake ? timeout_wake_o : timeout_reset_o) !== 1'b1
               && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        check_bit(n >= exp - 1 && n <= exp + 1, 1'b1,
                  "timeout period");
        if (n >= 2000) tally_and_finish();
    endtask

    initial begin
        rstn_i = 1'b0;
        cfg_i = '0;
        clr_i = '0;
        sleeping_i = 1'b0;
        clk_fail_i = 1'b0;
        osc_freq_sel_i = '0;
        ctl_wr_i = 1'b0;
        ctl_swen_i = 1'b0;
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (12) @(negedge clk_i);
        check_bit(post_count_o === '0, 1'b1, "counts while off");
        write_ctl(1'b1);
        check_bit(ctl_swen_o, 1'b1, "swen readback");
        check_bit(active_o, 1'b1, "swen enable");
        check_bit(osc_enable_o, 1'b1, "osc request");
        // every short select doubles the period
        for (int n = 0; n < 6; n++) begin
            cfg_i.post_sel = n[SEL_W-1:0];
            kick(0);
            measure(BC << n, 1'b0);
        end
        cfg_i.post_sel = 4'h3;
        kick(0);
        repeat (4 * BC + 2) @(negedge clk_i);
        check_bit(post_count_o === 16'h0004, 1'b1, "postscaler");
        // each clear source but clear_exec restarts a half-run period; the pin path
        // lands two cycles late, so it must still beat the expiry
        cfg_i.post_sel = 4'h1;
        for (int k = 1; k < 5; k++) begin
            kick(0);
            repeat (4) @(negedge clk_i);
            kick(k);
            measure((BC << 1) + (k == 3 ? 2 : 0),
                    1'b0);
        end
        sleeping_i = 1'b1;
        kick(1);
        measure(BC << 1, 1'b1);
        sleeping_i = 1'b0;
        write_ctl(1'b0);
        check_bit(active_o, 1'b0, "swen off");
        cfg_i.cfg_enable = 1'b1;
        write_ctl(1'b0);
        check_bit(active_o, 1'b1, "config wins");
        tally_and_finish();
    end
endmodule
`default_nettype wire
